// ===== mac_tx_pkg.sv
// Constants, types and helpers for the transmit access controller
package mac_tx_pkg;

  localparam logic [1:0]  MODE_HDR_ACK   = 2'h0;
  localparam logic [1:0]  MODE_RAW       = 2'h1;
  localparam logic [1:0]  MODE_RAW_ACK   = 2'h2;
  localparam logic [1:0]  MODE_HDR       = 2'h3;
  localparam logic [1:0]  MODE_DEFAULT   = 2'h0;
  localparam logic [7:0]  THR_DEFAULT    = 8'h32;
  localparam logic [7:0]  THR_OFF        = 8'h00;
  localparam logic [2:0]  BE_DEFAULT     = 3'h0;
  localparam logic [2:0]  BE_MAX         = 3'h5;
  localparam logic [2:0]  RETRY_DEFAULT  = 3'h0;
  localparam logic [2:0]  MAC_RETRIES    = 3'h5;
  localparam logic [2:0]  ED_CYCLES      = 3'h6;
  localparam logic [15:0] FAIL_MAX       = 16'hFFFF;
  localparam logic [15:0] BCAST_ADDR     = 16'hFFFF;
  localparam logic [7:0]  FID_NONE       = 8'h00;

  localparam logic [7:0]  ST_SUCCESS     = 8'h00;
  localparam logic [7:0]  ST_NO_ACK      = 8'h01;
  localparam logic [7:0]  ST_CCA_FAIL    = 8'h02;
  localparam logic [7:0]  ST_NET_ACK     = 8'h21;

  localparam int          CLK_MHZ        = 250;
  localparam int          SYMBOL_NS      = 16000;
  localparam int          BACKOFF_SYMS   = 20;
  localparam int          BACKOFF_CYC    =
    BACKOFF_SYMS * SYMBOL_NS * CLK_MHZ / 1000;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYC         = MS_NS * CLK_MHZ / 1000;
  localparam logic [15:0] APP_DLY_MIN_MS = 16'h0001;
  localparam logic [15:0] APP_DLY_MAX_MS = 16'h0030;

  localparam logic [1:0]  BUF_DEPTH      = 2'h2;
  localparam logic [15:0] LFSR_SEED      = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS      = 16'hB400;

  typedef struct packed {
    logic [15:0] dest;
    logic [7:0]  fid;
  } desc_s;

  function automatic logic hdr_enabled(input logic [1:0] mode);
    hdr_enabled = (mode == MODE_HDR_ACK) || (mode == MODE_HDR);
  endfunction

  function automatic logic ack_enabled(input logic [1:0] mode);
    ack_enabled = (mode == MODE_HDR_ACK) || (mode == MODE_RAW_ACK);
  endfunction

  function automatic logic [15:0] be_mask(input logic [2:0] be);
    be_mask = (16'h0001 << be) - 16'h0001;
  endfunction

endpackage

// ===== mac_tx_if.sv
// Carrier between the access core, its request buffer and random source
`timescale 1ns/1ps
`default_nettype none
interface mac_tx_if;
  mac_tx_pkg::desc_s desc;
  logic              desc_valid;
  logic              desc_ready;
  logic [15:0]       rnd;

  modport buf_src (output desc, output desc_valid, input desc_ready);
  modport core    (input desc, input desc_valid, input rnd,
                   output desc_ready);
  modport rng_src (output rnd);
endinterface
`default_nettype wire

// ===== tx_desc_buffer.sv
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tx_desc_buffer (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              in_valid,
  input  wire mac_tx_pkg::desc_s in_desc,
  output logic                   in_ready,
  mac_tx_if.buf_src              q
);
  typedef struct packed {
    mac_tx_pkg::desc_s [1:0] ent;
    logic [1:0]              cnt;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic   push;
  logic   pop;

  always_comb begin
    st_next = st_reg;
    push = in_valid && (st_reg.cnt != mac_tx_pkg::BUF_DEPTH);
    pop  = q.desc_ready && (st_reg.cnt != 2'h0);
    if (pop) begin
      st_next.ent[0] = st_reg.ent[1];
      st_next.cnt    = st_reg.cnt - 2'h1;
    end
    if (push) begin
      st_next.ent[st_next.cnt[0]] = in_desc;
      st_next.cnt                 = st_next.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Full refusal reaches the source, so a stalled core drops nothing
  assign in_ready     = st_reg.cnt != mac_tx_pkg::BUF_DEPTH;
  assign q.desc_valid = st_reg.cnt != 2'h0;
  assign q.desc       = st_reg.ent[0];
endmodule
`default_nettype wire

// ===== lfsr_rng.sv
// Free-running pseudo-random source for backoff and retry delays
`timescale 1ns/1ps
`default_nettype none
module lfsr_rng (
  input  wire logic clk,
  input  wire logic rst_b,
  mac_tx_if.rng_src r
);
  typedef struct packed {
    logic [15:0] lfsr;
  } state_s;

  state_s st_reg;
  state_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.lfsr = {1'b0, st_reg.lfsr[15:1]}
                   ^ (st_reg.lfsr[0] ? mac_tx_pkg::LFSR_TAPS : 16'h0000);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{lfsr: mac_tx_pkg::LFSR_SEED};
    end else begin
      st_reg <= st_next;
    end
  end

  assign r.rnd = st_reg.lfsr;
endmodule
`default_nettype wire

// ===== mac_tx_access.sv
// Transmit medium access: assessment, backoff, retries and status
`timescale 1ns/1ps
`default_nettype none
module mac_tx_access #(
  parameter int BACKOFF_CYCLES = mac_tx_pkg::BACKOFF_CYC,
  parameter int MS_CYCLES      = mac_tx_pkg::MS_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Configuration
  input  wire logic        CFG_WRITE,
  input  wire logic        CFG_DEFAULTS,
  input  wire logic        BOOT,
  input  wire logic [1:0]  MAC_MODE_SELECT,
  input  wire logic [7:0]  CHANNEL_ENERGY_THRESHOLD,
  input  wire logic [2:0]  BACKOFF_EXPONENT_MIN,
  input  wire logic [2:0]  APP_RETRY_COUNT,
  output logic [1:0]       MAC_MODE_ACTIVE,
  output logic             DUP_DETECT_EN,
  // Failure statistics
  input  wire logic        CHANNEL_FAIL_CLEAR,
  output logic [15:0]      CHANNEL_FAIL_COUNTER,
  // Transmit requests
  input  wire logic        TX_VALID,
  output logic             TX_READY,
  input  wire logic [15:0] TX_DEST,
  input  wire logic [7:0]  TX_FRAME_ID,
  // Energy detection
  output logic             ED_START,
  input  wire logic        ED_DONE,
  input  wire logic [7:0]  ED_LEVEL,
  // Radio transmit
  output logic             RADIO_START,
  output logic             RADIO_ACK_REQ,
  output logic             RADIO_VENDOR_HDR,
  output logic [15:0]      RADIO_DEST,
  input  wire logic        RADIO_DONE,
  input  wire logic        RADIO_ACKED,
  // Transmit status
  output logic             STATUS_VALID,
  output logic [7:0]       STATUS_FRAME_ID,
  output logic [7:0]       STATUS_CODE
);

  typedef enum logic [2:0] {
    IDLE,
    BACKOFF,
    ED_REQ,
    ED_WAIT,
    TX_REQ,
    TX_WAIT,
    APP_WAIT
  } state_e;

  typedef struct packed {
    state_e            fsm;
    mac_tx_pkg::desc_s cur;
    logic [1:0]        mode;
    logic [7:0]        thr_cfg;
    logic [7:0]        thr_act;
    logic [2:0]        be_min;
    logic [2:0]        retries;
    logic [2:0]        be;
    logic [15:0]       periods;
    logic [31:0]       tick;
    logic [2:0]        ed_cnt;
    logic [2:0]        mac_cnt;
    logic [2:0]        app_cnt;
    logic [15:0]       fail_cnt;
    logic              ed_start;
    logic              radio_start;
    logic              ack_req;
    logic              hdr;
    logic              st_valid;
    logic [7:0]        st_code;
    logic [7:0]        st_fid;
  } core_s;

  localparam core_s CORE_INIT = '{
    fsm:     IDLE,
    mode:    mac_tx_pkg::MODE_DEFAULT,
    thr_cfg: mac_tx_pkg::THR_DEFAULT,
    thr_act: mac_tx_pkg::THR_DEFAULT,
    be_min:  mac_tx_pkg::BE_DEFAULT,
    retries: mac_tx_pkg::RETRY_DEFAULT,
    default: '0
  };

  localparam logic [31:0] BO_LAST = 32'(BACKOFF_CYCLES - 1);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
  localparam logic [2:0]  ED_LAST = mac_tx_pkg::ED_CYCLES - 3'h1;
  localparam logic [15:0] APP_SPAN =
    mac_tx_pkg::APP_DLY_MAX_MS - mac_tx_pkg::APP_DLY_MIN_MS + 16'h0001;

  core_s st_reg;
  core_s st_next;

  mac_tx_if link ();

  tx_desc_buffer u_buf (
    .clk      (CLK),
    .rst_b    (RST_B),
    .in_valid (TX_VALID),
    .in_desc  ({TX_DEST, TX_FRAME_ID}),
    .in_ready (TX_READY),
    .q        (link.buf_src)
  );

  lfsr_rng u_rng (
    .clk   (CLK),
    .rst_b (RST_B),
    .r     (link.rng_src)
  );

  // Fresh channel access: exponent back to its minimum, new random wait
  function automatic core_s begin_access(input core_s s,
                                         input logic [15:0] rnd);
    core_s t;
    t         = s;
    t.be      = s.be_min;
    t.ed_cnt  = 3'h0;
    t.tick    = 32'h0000_0000;
    t.periods = rnd & mac_tx_pkg::be_mask(s.be_min);
    t.fsm     = BACKOFF;
    return t;
  endfunction

  // Application retry after a random whole number of milliseconds
  function automatic core_s app_retry(input core_s s,
                                      input logic [15:0] rnd);
    core_s t;
    t         = s;
    t.app_cnt = s.app_cnt + 3'h1;
    t.mac_cnt = 3'h0;
    t.tick    = 32'h0000_0000;
    t.periods = mac_tx_pkg::APP_DLY_MIN_MS + (rnd % APP_SPAN);
    t.fsm     = APP_WAIT;
    return t;
  endfunction

  function automatic core_s finish(input core_s s, input logic [7:0] code);
    core_s t;
    t          = s;
    t.st_valid = s.cur.fid != mac_tx_pkg::FID_NONE;
    t.st_code  = code;
    t.st_fid   = s.cur.fid;
    t.fsm      = IDLE;
    return t;
  endfunction

  logic is_bcast;
  logic ack_bit;
  logic hdr_bit;
  logic cca_on;
  logic busy;
  logic app_ok;

  always_comb begin
    st_next = st_reg;
    st_next.ed_start    = 1'b0;
    st_next.radio_start = 1'b0;
    st_next.st_valid    = 1'b0;

    is_bcast = st_reg.cur.dest == mac_tx_pkg::BCAST_ADDR;
    hdr_bit  = mac_tx_pkg::hdr_enabled(st_reg.mode);
    // Broadcast never asks for an acknowledgment
    ack_bit  = mac_tx_pkg::ack_enabled(st_reg.mode)
               && !is_bcast;
    // A zero threshold disables assessment at once; others wait for boot
    cca_on   = (st_reg.thr_cfg != mac_tx_pkg::THR_OFF)
               && (st_reg.thr_act != mac_tx_pkg::THR_OFF);
    // Level is the magnitude of a negative dBm figure: smaller is louder
    busy     = ED_LEVEL < st_reg.thr_act;
    app_ok   = hdr_bit && (st_reg.app_cnt < st_reg.retries);

    if (CFG_DEFAULTS) begin
      st_next.mode    = mac_tx_pkg::MODE_DEFAULT;
      st_next.thr_cfg = mac_tx_pkg::THR_DEFAULT;
      st_next.be_min  = mac_tx_pkg::BE_DEFAULT;
      st_next.retries = mac_tx_pkg::RETRY_DEFAULT;
    end else if (CFG_WRITE) begin
      st_next.mode    = MAC_MODE_SELECT;
      st_next.thr_cfg = CHANNEL_ENERGY_THRESHOLD;
      st_next.be_min  = BACKOFF_EXPONENT_MIN;
      st_next.retries = APP_RETRY_COUNT;
    end
    if (BOOT) begin
      st_next.thr_act = st_reg.thr_cfg;
    end

    if (CHANNEL_FAIL_CLEAR) begin
      st_next.fail_cnt = 16'h0000;
    end

    case (st_reg.fsm)
      IDLE: begin
        if (link.desc_valid) begin
          st_next.cur     = link.desc;
          st_next.mac_cnt = 3'h0;
          st_next.app_cnt = 3'h0;
          st_next         = begin_access(st_next, link.rnd);
        end
      end
      BACKOFF: begin
        if (st_reg.periods == 16'h0000) begin
          st_next.tick = 32'h0000_0000;
          st_next.fsm  = cca_on ? ED_REQ : TX_REQ;
        end else if (st_reg.tick == BO_LAST) begin
          st_next.tick    = 32'h0000_0000;
          st_next.periods = st_reg.periods - 16'h0001;
        end else begin
          st_next.tick = st_reg.tick + 32'h0000_0001;
        end
      end
      ED_REQ: begin
        st_next.ed_start = 1'b1;
        st_next.fsm      = ED_WAIT;
      end
      ED_WAIT: begin
        if (ED_DONE) begin
          if (!busy) begin
            st_next.fsm = TX_REQ;
          end else if (st_reg.ed_cnt == ED_LAST) begin
            // Set wins over a clear arriving in the same cycle
            if (st_reg.fail_cnt != mac_tx_pkg::FAIL_MAX) begin
              st_next.fail_cnt = st_reg.fail_cnt + 16'h0001;
            end else begin
              st_next.fail_cnt = mac_tx_pkg::FAIL_MAX;
            end
            if (app_ok) begin
              st_next = app_retry(st_next, link.rnd);
            end else begin
              st_next = finish(st_next, mac_tx_pkg::ST_CCA_FAIL);
            end
          end else begin
            st_next.ed_cnt = st_reg.ed_cnt + 3'h1;
            if (st_reg.be != mac_tx_pkg::BE_MAX) begin
              st_next.be = st_reg.be + 3'h1;
            end
            st_next.periods = link.rnd
                              & mac_tx_pkg::be_mask(st_next.be);
            st_next.tick    = 32'h0000_0000;
            st_next.fsm     = BACKOFF;
          end
        end
      end
      TX_REQ: begin
        st_next.radio_start = 1'b1;
        st_next.ack_req     = ack_bit;
        st_next.hdr         = hdr_bit;
        st_next.fsm         = TX_WAIT;
      end
      TX_WAIT: begin
        if (RADIO_DONE) begin
          if (!st_reg.ack_req || RADIO_ACKED) begin
            st_next = finish(st_next, mac_tx_pkg::ST_SUCCESS);
          end else if (st_reg.mac_cnt != mac_tx_pkg::MAC_RETRIES) begin
            st_next.mac_cnt = st_reg.mac_cnt + 3'h1;
            st_next         = begin_access(st_next, link.rnd);
          end else if (app_ok) begin
            st_next = app_retry(st_next, link.rnd);
          end else if (hdr_bit && (st_reg.retries != 3'h0)) begin
            st_next = finish(st_next, mac_tx_pkg::ST_NET_ACK);
          end else begin
            st_next = finish(st_next, mac_tx_pkg::ST_NO_ACK);
          end
        end
      end
      APP_WAIT: begin
        if (st_reg.tick == MS_LAST) begin
          st_next.tick = 32'h0000_0000;
          if (st_reg.periods == 16'h0001) begin
            st_next = begin_access(st_next, link.rnd);
          end else begin
            st_next.periods = st_reg.periods - 16'h0001;
          end
        end else begin
          st_next.tick = st_reg.tick + 32'h0000_0001;
        end
      end
      default: begin
        st_next.fsm = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= CORE_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // The core takes a request only while idle, so stalls fill the buffer
  assign link.desc_ready = st_reg.fsm == IDLE;

  assign MAC_MODE_ACTIVE      = st_reg.mode;
  assign DUP_DETECT_EN        = mac_tx_pkg::hdr_enabled(st_reg.mode);
  assign CHANNEL_FAIL_COUNTER = st_reg.fail_cnt;
  assign ED_START             = st_reg.ed_start;
  assign RADIO_START          = st_reg.radio_start;
  assign RADIO_ACK_REQ        = st_reg.ack_req;
  assign RADIO_VENDOR_HDR     = st_reg.hdr;
  assign RADIO_DEST           = st_reg.cur.dest;
  assign STATUS_VALID         = st_reg.st_valid;
  assign STATUS_FRAME_ID      = st_reg.st_fid;
  assign STATUS_CODE          = st_reg.st_code;
endmodule
`default_nettype wire

// ===== mac_tx_checker.sv
// Port assertions for the transmit access controller
`timescale 1ns/1ps
`default_nettype none
module mac_tx_checker (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CFG_WRITE,
  input wire logic        CFG_DEFAULTS,
  input wire logic [1:0]  MAC_MODE_SELECT,
  input wire logic [1:0]  MAC_MODE_ACTIVE,
  input wire logic        DUP_DETECT_EN,
  input wire logic        CHANNEL_FAIL_CLEAR,
  input wire logic [15:0] CHANNEL_FAIL_COUNTER,
  input wire logic        RADIO_START,
  input wire logic        RADIO_ACK_REQ,
  input wire logic        RADIO_VENDOR_HDR,
  input wire logic [15:0] RADIO_DEST,
  input wire logic        STATUS_VALID,
  input wire logic [7:0]  STATUS_FRAME_ID,
  input wire logic [7:0]  STATUS_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic        hdr;
  logic        ack;
  logic [15:0] cnt;
  assign hdr = MAC_MODE_ACTIVE == 2'h0 || MAC_MODE_ACTIVE == 2'h3;
  assign ack = MAC_MODE_ACTIVE == 2'h0 || MAC_MODE_ACTIVE == 2'h2;
  assign cnt = CHANNEL_FAIL_COUNTER;
  cfg_load_a: assert property (
    CFG_WRITE && !CFG_DEFAULTS |=> MAC_MODE_ACTIVE == $past(MAC_MODE_SELECT))
    else $error("mode not loaded");
  dup_decode_a: assert property (
    DUP_DETECT_EN == hdr) else $error("duplicate detect decode wrong");
  mode_default_a: assert property (
    CFG_DEFAULTS |=> MAC_MODE_ACTIVE == 2'h0 && DUP_DETECT_EN)
    else $error("defaults not applied");
  bcast_noack_a: assert property (
    RADIO_START && RADIO_DEST == 16'hFFFF |-> !RADIO_ACK_REQ)
    else $error("broadcast asks for ack");
  ucast_ack_a: assert property (
    RADIO_START && RADIO_DEST != 16'hFFFF |-> RADIO_ACK_REQ == ack)
    else $error("unicast ack request wrong");
  vendor_hdr_a: assert property (
    RADIO_START |-> RADIO_VENDOR_HDR == hdr) else $error("header flag wrong");
  fail_step_a: assert property (
    !CHANNEL_FAIL_CLEAR |=> cnt == $past(cnt) ||
    ($past(cnt) != 16'hFFFF && cnt == $past(cnt) + 16'h0001))
    else $error("failure counter step wrong");
  fail_clear_a: assert property (
    CHANNEL_FAIL_CLEAR |=> cnt == 16'h0000 || cnt == $past(cnt) + 16'h0001)
    else $error("failure counter not cleared");
  status_fid_a: assert property (
    STATUS_VALID |-> STATUS_FRAME_ID != 8'h00)
    else $error("silent id reported");
  cover property (STATUS_VALID && STATUS_CODE == 8'h21);
  cover property (STATUS_VALID && STATUS_CODE == 8'h02);
  cover property (RADIO_START && RADIO_DEST == 16'hFFFF);
endmodule
bind mac_tx_access mac_tx_checker chk (.CLK(CLK), .RST_B(RST_B),
  .CFG_WRITE(CFG_WRITE), .CFG_DEFAULTS(CFG_DEFAULTS),
  .MAC_MODE_SELECT(MAC_MODE_SELECT), .MAC_MODE_ACTIVE(MAC_MODE_ACTIVE),
  .DUP_DETECT_EN(DUP_DETECT_EN), .CHANNEL_FAIL_CLEAR(CHANNEL_FAIL_CLEAR),
  .CHANNEL_FAIL_COUNTER(CHANNEL_FAIL_COUNTER), .RADIO_START(RADIO_START),
  .RADIO_ACK_REQ(RADIO_ACK_REQ), .RADIO_VENDOR_HDR(RADIO_VENDOR_HDR),
  .RADIO_DEST(RADIO_DEST), .STATUS_VALID(STATUS_VALID),
  .STATUS_FRAME_ID(STATUS_FRAME_ID), .STATUS_CODE(STATUS_CODE));
`default_nettype wire

// ===== radio_peer_model.sv
// Energy detector and peer radio seen from the access controller
`timescale 1ns/1ps
`default_nettype none
module radio_peer_model (
  input  wire logic       clk,
  input  wire logic       ed_start,
  output logic            ed_done,
  output logic [7:0]      ed_level,
  input  wire logic       radio_start,
  input  wire logic       radio_ack_req,
  output logic            radio_done,
  output logic            radio_acked,
  input  wire logic [7:0] energy,
  input  wire logic       ack_ok,
  input  wire logic [7:0] delay
);
  logic req;
  initial begin
    ed_done = 1'b0;
    ed_level = 8'h00;
    radio_done = 1'b0;
    radio_acked = 1'b0;
  end
  // Level is garbage outside the done pulse
  always @(posedge clk) begin
    if (ed_start === 1'b1) begin
      repeat (2) @(posedge clk);
      ed_done <= 1'b1;
      ed_level <= energy;
      @(posedge clk);
      ed_done <= 1'b0;
      ed_level <= ~energy;
    end
  end
  always @(posedge clk) begin
    if (radio_start === 1'b1) begin
      req = radio_ack_req;
      repeat (delay) @(posedge clk);
      radio_done <= 1'b1;
      radio_acked <= req && ack_ok;
      @(posedge clk);
      radio_done <= 1'b0;
      radio_acked <= ~radio_acked;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the transmit access controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst_b = 1'b0, boot = 1'b0, fail_clr = 1'b0;
  logic        cfg_write = 1'b0, cfg_defaults = 1'b0, tx_valid = 1'b0;
  logic        ack_ok = 1'b1;
  logic [1:0]  mode = 2'h0, mode_act;
  logic [2:0]  be = 3'h0, retries = 3'h0;
  logic [7:0]  thr = 8'h00, tx_fid = 8'h00, energy = 8'h46, delay = 8'h03;
  logic [7:0]  ed_level, st_fid, st_code, fid;
  logic [15:0] tx_dest = 16'h0000, fail_cnt, r_dest, c, exp_fail, seen_dest;
  logic        dup_en, tx_ready, ed_start, ed_done, r_start, r_ack, r_hdr;
  logic        r_done, r_acked, st_valid, seen_ack, seen_hdr;
  logic [25:0] p;
  int          miscompares = 0, total_checks = 0, n_ed = 0, n_tx = 0;
  int          n_st = 0, i, n;
  logic [15:0] tab [11] = '{16'h0001, 16'h1001, 16'h2011, 16'h3200,
    16'h0000, 16'h0100, 16'h0021, 16'h3121, 16'h0002, 16'h2100, 16'h0111};

  mac_tx_access #(.BACKOFF_CYCLES(4), .MS_CYCLES(8)) uut (
    .CLK(clk), .RST_B(rst_b), .CFG_WRITE(cfg_write),
    .CFG_DEFAULTS(cfg_defaults), .BOOT(boot), .MAC_MODE_SELECT(mode),
    .CHANNEL_ENERGY_THRESHOLD(thr), .BACKOFF_EXPONENT_MIN(be),
    .APP_RETRY_COUNT(retries), .MAC_MODE_ACTIVE(mode_act),
    .DUP_DETECT_EN(dup_en), .CHANNEL_FAIL_CLEAR(fail_clr),
    .CHANNEL_FAIL_COUNTER(fail_cnt), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_DEST(tx_dest), .TX_FRAME_ID(tx_fid),
    .ED_START(ed_start), .ED_DONE(ed_done), .ED_LEVEL(ed_level),
    .RADIO_START(r_start), .RADIO_ACK_REQ(r_ack), .RADIO_VENDOR_HDR(r_hdr),
    .RADIO_DEST(r_dest), .RADIO_DONE(r_done), .RADIO_ACKED(r_acked),
    .STATUS_VALID(st_valid), .STATUS_FRAME_ID(st_fid),
    .STATUS_CODE(st_code));
  radio_peer_model peer (.clk(clk), .ed_start(ed_start), .ed_done(ed_done),
    .ed_level(ed_level), .radio_start(r_start), .radio_ack_req(r_ack),
    .radio_done(r_done), .radio_acked(r_acked), .energy(energy),
    .ack_ok(ack_ok), .delay(delay));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (ed_start === 1'b1) n_ed++;
    if (st_valid === 1'b1) n_st++;
    if (r_start === 1'b1) begin
      n_tx++;
      seen_ack = r_ack;
      seen_hdr = r_hdr;
      seen_dest = r_dest;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Every wait is bounded; a hang ends the run as a mismatch
  task automatic tick(inout int k);
    @(posedge clk);
    k++;
    if (k > 9000) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic cfg(input logic [1:0] m, input logic [7:0] t,
                     input logic [2:0] r, input logic [2:0] b);
    mode <= m;
    thr <= t;
    retries <= r;
    be <= b;
    cfg_write <= 1'b1;
    @(posedge clk);
    cfg_write <= 1'b0;
    @(posedge clk);
  endtask
  // Valid is left high so back-to-back pushes need no gap
  task automatic push(input logic [15:0] d, input logic [7:0] f);
    int k;
    k = 0;
    tx_dest <= d;
    tx_fid <= f;
    tx_valid <= 1'b1;
    do tick(k); while (tx_ready !== 1'b1);
  endtask
  task automatic wait_st(input logic [7:0] f, input logic [7:0] code);
    int k;
    k = 0;
    do tick(k); while (st_valid !== 1'b1);
    check("status id", st_fid, f);
    check("status code", st_code, code);
  endtask
  task automatic send(input logic [15:0] d, input logic [7:0] f,
                      input logic [7:0] code);
    push(d, f);
    tx_valid <= 1'b0;
    wait_st(f, code);
  endtask
  // Case word: mode, retries, channel (0 off, 1 clear, 2 busy), ack/bcast
  function automatic logic [25:0] predict(input logic [15:0] w);
    logic       h, a, nak;
    logic [7:0] k, t;
    h = w[13:12] == 2'h0 || w[13:12] == 2'h3;
    a = (w[13:12] == 2'h0 || w[13:12] == 2'h2) && !w[1];
    nak = a && !w[0];
    k = h ? 8'(w[10:8]) + 8'h01 : 8'h01;
    t = nak ? 8'h06 * k : 8'h01;
    if (w[5]) return {h, a, 8'h02, 8'h00, 8'h06 * k};
    return {h, a, nak ? (h && w[10:8] != 3'h0 ? 8'h21 : 8'h01) : 8'h00,
            t, w[4] ? t : 8'h00};
  endfunction

  initial begin
    void'($urandom(85));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    exp_fail = 16'h0000;
    check("reset mode", mode_act, 2'h0);
    check("reset ready", tx_ready, 1'b1);
    check("reset counter", fail_cnt, 16'h0000);
    cfg(2'h3, 8'h00, 3'h0, 3'h0);
    cfg_defaults <= 1'b1;
    @(posedge clk);
    cfg_defaults <= 1'b0;
    @(posedge clk);
    check("default mode", mode_act, 2'h0);
    $display("test defaults done");
    for (i = 0; i < 11; i++) begin
      c = tab[i];
      p = predict(c);
      cfg(c[13:12], c[5:4] == 2'h0 ? 8'h00 : 8'h32, c[10:8], 3'($urandom % 3));
      energy <= c[5] ? 8'h2D : 8'h46;
      ack_ok <= c[0];
      n_ed = 0;
      n_tx = 0;
      fid = 8'($urandom % 255 + 1);
      send(c[1] ? 16'hFFFF : 16'($urandom % 32'h0000_FFFF), fid, p[23:16]);
      check("radio starts", 16'(n_tx), 16'(p[15:8]));
      check("detections", 16'(n_ed), 16'(p[7:0]));
      if (p[15:8] != 8'h00) begin
        check("ack request", seen_ack, p[24]);
        check("vendor header", seen_hdr, p[25]);
        check("radio dest", seen_dest, tx_dest);
      end
      check("dup detect", dup_en, p[25]);
      check("active mode", mode_act, c[13:12]);
      exp_fail = exp_fail + 16'(c[5] ? p[7:0] / 8'h06 : 8'h00);
      repeat (2) @(posedge clk);
      check("fail counter", fail_cnt, exp_fail);
      $display("test case %0d done", i);
    end
    cfg(2'h1, 8'h00, 3'h0, 3'h0);
    n_st = 0;
    n_tx = 0;
    push(16'h1234, 8'h00);
    tx_valid <= 1'b0;
    n = 0;
    do tick(n); while (r_start !== 1'b1);
    check("start latency", 16'(n), 16'h0004);
    repeat (40) @(posedge clk);
    check("silent status", 16'(n_st), 16'h0000);
    check("silent sent", 16'(n_tx), 16'h0001);
    $display("test silent frame done");
    cfg(2'h1, 8'h10, 3'h0, 3'h0);
    energy <= 8'h2D;
    send(16'h0042, 8'h11, 8'h02);
    boot <= 1'b1;
    @(posedge clk);
    boot <= 1'b0;
    send(16'h0042, 8'h12, 8'h00);
    fail_clr <= 1'b1;
    @(posedge clk);
    fail_clr <= 1'b0;
    @(posedge clk);
    check("cleared counter", fail_cnt, 16'h0000);
    $display("test threshold and clear done");
    cfg(2'h1, 8'h00, 3'h0, 3'h0);
    delay <= 8'h3C;
    for (i = 1; i < 4; i++) push(16'h0100, 8'(i));
    tx_valid <= 1'b0;
    repeat (5) @(posedge clk);
    check("buffer full", tx_ready, 1'b0);
    for (i = 1; i < 4; i++) wait_st(8'(i), 8'h00);
    $display("test buffer done");
    stop_test();
  end
endmodule
`default_nettype wire
